/* File: dv/ees_master.sv */
`default_nettype none

// behavioural bus master, mode 0, SCK still between frames
module ees_master (
	// driven pins
	output logic      cs_n,
	output logic      sck,
	output logic      si,
	output logic      hold_n,
	// return line
	input  wire logic so,
	input  wire logic so_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic last = 1'b1; // last level the device drove
	wire  line;        // what the master really sees

	// a released line shows the inverse of its last level, so stale data never passes
	assign line = so_oe ? so : ~last;
	always @(so or so_oe) if (so_oe) last = so;

	// every pin held at a defined level from time zero
	initial begin
		cs_n = 1'b1;
		sck = 1'b0;
		si = 1'b0;
		hold_n = 1'b1;
	end
	// one bit: SI set while SCK low, return sampled at the rise
	task xbit(input logic b, output logic r);
		si = b;
		#6 sck = 1'b1;
		r = line;
		#6 sck = 1'b0;
	endtask
	task xbyte(input logic [7:0] d, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
	endtask
	// odd delay keeps the link edges off the core clock edges
	task start();
		#1.3 cs_n = 1'b0;
		#20;
	endtask
	task stop();
		#20 cs_n = 1'b1;
		#100;
	endtask
	// pause with SCK low, clock junk meanwhile, resume with SCK low
	task pause(input int n);
		hold_n = 1'b0;
		#3;
		repeat (n) begin
			si = 1'($urandom);
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
		hold_n = 1'b1;
		#3;
	endtask
endmodule

`default_nettype wire

/* File: dv/ees_spi_front_chk.sv */
`default_nettype none

// pin and frame level checks on the serial front end
module ees_spi_front_chk (
	// core clock and reset
	input wire logic               I_MCLK,
	input wire logic               I_RESET_N,
	input wire logic               I_CE,
	// serial pins
	input wire logic               I_CS_N,
	input wire logic               I_SCK,
	input wire logic               I_HOLD_N,
	input wire logic               O_SO,
	input wire logic               O_SO_OE,
	// frame, transmit and protection
	input wire logic               O_SELECTED,
	input wire logic               O_PAUSED,
	input wire logic               O_FRAME_START,
	input wire ees_pkg::ees_byte_t O_RX,
	input wire logic               I_TX_LOAD,
	input wire logic               O_TX_READY,
	input wire logic               I_WP_GATE_EN,
	input wire logic               O_WP_BLOCK,
	input wire logic               O_FRAME_END,
	input wire logic               O_SR_COMMIT,
	input wire logic               O_SR_ABORT
);
	// one domain only, so clock and disable are given once
	default clocking cb @(posedge I_MCLK);
	endclocking
	default disable iff (!I_RESET_N);

	a_float_desel: assert property (I_CS_N |-> !O_SO_OE)
		else $error("SO driven while deselected");
	a_float_hold: assert property (!I_HOLD_N |-> !O_SO_OE)
		else $error("SO driven while paused");
	// SO may only move after a falling SCK edge, never while SCK stays high
	a_so_steady: assert property (I_SCK && $past(I_SCK) && !I_CS_N && !$past(I_CS_N)
		|-> $stable(O_SO)) else $error("SO moved while SCK high");
	a_desel_level: assert property (I_CS_N [*4] |=> !O_SELECTED)
		else $error("selected with chip select high");
	a_pause_sel: assert property (O_PAUSED |-> O_SELECTED && !$past(I_HOLD_N, 3))
		else $error("paused without selected hold");
	a_start_sel: assert property (O_FRAME_START |-> !I_CS_N ##1 !O_FRAME_START)
		else $error("frame start outside a frame");
	a_rx_pulse: assert property (O_RX.valid |=> !O_RX.valid)
		else $error("byte valid longer than one cycle");
	a_tx_take: assert property (I_CE && I_TX_LOAD && O_TX_READY |=> !O_TX_READY)
		else $error("offered byte not taken");
	a_gate_off: assert property (!$past(I_WP_GATE_EN) |-> !O_WP_BLOCK)
		else $error("protect block with gate clear");
	a_sr_end: assert property ((O_SR_COMMIT || O_SR_ABORT)
		|-> O_FRAME_END && !(O_SR_COMMIT && O_SR_ABORT)) else $error("bad status verdict");
	a_abort_gate: assert property (O_SR_ABORT |-> I_WP_GATE_EN)
		else $error("abort with gate clear");
endmodule

bind ees_spi_front ees_spi_front_chk i_chk (
	.I_MCLK(I_MCLK), .I_RESET_N(I_RESET_N), .I_CE(I_CE), .I_CS_N(I_CS_N),
	.I_SCK(I_SCK), .I_HOLD_N(I_HOLD_N), .O_SO(O_SO), .O_SO_OE(O_SO_OE),
	.O_SELECTED(O_SELECTED), .O_PAUSED(O_PAUSED), .O_FRAME_START(O_FRAME_START),
	.O_RX(O_RX), .I_TX_LOAD(I_TX_LOAD), .O_TX_READY(O_TX_READY),
	.I_WP_GATE_EN(I_WP_GATE_EN), .O_WP_BLOCK(O_WP_BLOCK), .O_FRAME_END(O_FRAME_END),
	.O_SR_COMMIT(O_SR_COMMIT), .O_SR_ABORT(O_SR_ABORT)
);

`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1, gate = 1'b0, sr_act = 1'b0;
	logic tx_load = 1'b0, mem_we = 1'b0, so, so_oe, sel, pz, fs, fe, wpb, cm, ab, rdy;
	logic [7:0]         tx_byte = 8'h00, mem_wd = 8'h00, mem_rd, a, b, r;
	logic [16:0]        mem_a = 17'h00000;
	logic               cs_n, sck, si, hold_n;
	ees_pkg::ees_byte_t rx;
	int                 n_fail, checks_done, n_cm, n_ab, n_pz, n_fs, n_fe, c0, a0;
	logic [7:0]         got[$], exp_q[$], md[2]; // model of received bytes

	always #2 clk = ~clk;

	ees_spi_front i_dut (.I_MCLK(clk), .I_RESET_N(rst_n), .I_CE(1'b1), .I_CS_N(cs_n),
		.I_SCK(sck), .I_SI(si), .O_SO(so), .O_SO_OE(so_oe), .I_WP_N(wp_n),
		.I_HOLD_N(hold_n), .O_SELECTED(sel), .O_PAUSED(pz), .O_FRAME_START(fs),
		.O_FRAME_END(fe), .O_RX(rx), .I_TX_BYTE(tx_byte), .I_TX_LOAD(tx_load),
		.O_TX_READY(rdy), .I_WP_GATE_EN(gate), .I_SR_WR_ACTIVE(sr_act), .O_WP_BLOCK(wpb),
		.O_SR_COMMIT(cm), .O_SR_ABORT(ab), .I_MEM_ADDR(mem_a), .I_MEM_WDATA(mem_wd),
		.I_MEM_WE(mem_we), .O_MEM_RDATA(mem_rd));
	ees_master i_mst (.cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so(so),
		.so_oe(so_oe));

	// collect bytes, verdicts and pause cycles as the design reports them
	always @(posedge clk) begin
		if (rx.valid === 1'b1) got.push_back(rx.data);
		if (cm === 1'b1) n_cm++;
		if (ab === 1'b1) n_ab++;
		if (pz === 1'b1) n_pz++;
		if (fs === 1'b1) n_fs++;
		if (fe === 1'b1) n_fe++;
	end

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		checks_done++;
		if (seen !== want) begin
			n_fail++;
			$display("Error %s expected %0h seen %0h", nm, want, seen);
		end
	endtask
	// received stream against the model, then both emptied
	task cmp_rx();
		chk("rx_count", got.size(), exp_q.size());
		while (got.size() > 0 && exp_q.size() > 0)
			chk("rx_byte", got.pop_front(), exp_q.pop_front());
		got.delete();
		exp_q.delete();
	endtask
	task stop_test();
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// a hang counts as a mismatch; the whole run needs well under this
	initial begin
		#100000;
		n_fail++;
		stop_test();
	end

	initial begin
		void'($urandom(52));
		repeat (10) @(posedge clk);
		chk("rst_ready", rdy, 1'b1);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		// offer one byte, then a two byte frame: in on the rise, out after the fall
		tx_byte <= 8'($urandom);
		tx_load <= 1'b1;
		@(posedge clk) tx_load <= 1'b0;
		#1 chk("tx_ready", rdy, 1'b0);
		a = 8'($urandom);
		b = 8'($urandom);
		exp_q = '{a, b};
		i_mst.start();
		i_mst.xbyte(a, r);
		i_mst.xbyte(b, r);
		chk("so_byte", r, tx_byte);
		i_mst.stop();
		cmp_rx();
		chk("tx_ready", rdy, 1'b1);
		$display("test shift done");
		// pause after three bits with SCK running, resume at the same bit
		a = 8'($urandom);
		exp_q = '{a};
		n_pz = 0;
		i_mst.start();
		for (int i = 7; i >= 0; i--) begin
			if (i == 4) i_mst.pause(4);
			i_mst.xbit(a[i], r[0]);
		end
		i_mst.stop();
		chk("paused", n_pz != 0, 1'b1);
		cmp_rx();
		$display("test hold done");
		// SCK and SI toggling with chip select high must leave no byte
		// a partial byte while deselected must not shift the next frame's bits
		repeat (5) i_mst.xbit(1'($urandom), r[0]);
		repeat (10) @(posedge clk);
		cmp_rx();
		a = 8'($urandom);
		exp_q = '{a};
		i_mst.start();
		i_mst.xbyte(a, r);
		i_mst.stop();
		cmp_rx();
		$display("test deselect done");
		// gate and pin cases: 0/low, 1/high, 1/low, fall in frame, fall after frame
		for (int k = 0; k < 5; k++) begin
			gate <= 1'(5'b11110 >> k);
			wp_n <= 1'(5'b11010 >> k);
			sr_act <= 1'b1;
			c0 = n_cm;
			a0 = n_ab;
			repeat (4) @(posedge clk);
			i_mst.start();
			i_mst.xbyte(8'($urandom), r);
			if (k == 3) @(posedge clk) wp_n <= 1'b0;
			i_mst.xbyte(8'($urandom), r);
			i_mst.stop();
			if (k == 4) @(posedge clk) wp_n <= 1'b0;
			repeat (8) @(posedge clk);
			chk("commit", n_cm - c0, (5'b10011 >> k) & 1);
			chk("abort", n_ab - a0, (5'b01100 >> k) & 1);
			chk("wp_block", wpb, gate & ~wp_n);
		end
		sr_act <= 1'b0;
		wp_n <= 1'b1;
		got.delete();
		// eight frames so far: shift, hold, deselect follow-up, five protect cases
		chk("frame_start", n_fs, 8);
		chk("frame_end", n_fe, 8);
		chk("selected", sel, 1'b0);
		$display("test protect done");
		// top and bottom bytes of the array hold separate values
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			mem_a <= k[0] ? 17'h1ffff : 17'h00000;
			md[k[0]] = (k < 2) ? 8'($urandom) : md[k[0]];
			mem_wd <= md[k[0]];
			mem_we <= (k < 2);
			@(posedge clk) mem_we <= 1'b0;
			#1 if (k >= 2) chk("mem", mem_rd, md[k[0]]);
		end
		$display("test array done");
		stop_test();
	end
endmodule

`default_nettype wire

/* File: verilog/ees_defs.svh */
`ifndef EES_DEFS_SVH
`define EES_DEFS_SVH

// width of one serial byte
`define EES_BYTE_W 8
// storage array depth in bytes and its address width
`define EES_DEPTH 131072
`define EES_ADDR_W 17
// bit position counter width inside one byte
`define EES_BIT_CNT_W 3
// counter value at the last bit of a byte
`define EES_BIT_LAST 3'h7
// reset value of the output shifter, idle level of SO
`define EES_TX_IDLE 8'hff
// reset value of the received byte
`define EES_RX_RESET 8'h00

`endif

/* File: verilog/ees_pkg.sv */
`default_nettype none

package ees_pkg;

	// one received byte with its one-cycle valid
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} ees_byte_t;

	// progress of a status register write within one frame
	typedef enum logic [1:0] {
		SR_IDLE,
		SR_OPEN,
		SR_KILLED
	} ees_sr_state_t;

endpackage

`default_nettype wire

/* File: verilog/ees_spi_front.sv */
// Function
// - selected only while chip select low
// - deselected: ignore serial input, output floats
// - no sequence before chip select low seen
// - output bits change after SCK falling
// - input bits sampled on SCK rising
// - serial input is the only entry path
// - protect pin high: no restriction
// - pin low, gate set: refuse status writes
// - pin falls mid-frame: abort status write
// - after commit, pin fall has no effect
// - gate clear: pin fully ignored
// - hold pauses without losing sequence state
// - hold asserted while SCK low pauses
// - hold released while SCK low resumes
// - paused: ignore input, output floats
// - array holds 131072 bytes
`include "ees_defs.svh"
`default_nettype none

module ees_spi_front #(
	parameter int DEPTH = `EES_DEPTH,
	parameter int AW    = `EES_ADDR_W
) (
	// core clock, reset and enable
	input  wire logic                 I_MCLK,
	input  wire logic                 I_RESET_N,
	input  wire logic                 I_CE,
	// serial pins
	input  wire logic                 I_CS_N,
	input  wire logic                 I_SCK,
	input  wire logic                 I_SI,
	output logic                      O_SO,
	output logic                      O_SO_OE,
	input  wire logic                 I_WP_N,
	input  wire logic                 I_HOLD_N,
	// frame events and state
	output logic                      O_SELECTED,
	output logic                      O_PAUSED,
	output logic                      O_FRAME_START,
	output logic                      O_FRAME_END,
	// received bytes
	output ees_pkg::ees_byte_t        O_RX,
	// byte to send next
	input  wire logic [7:0]           I_TX_BYTE,
	input  wire logic                 I_TX_LOAD,
	output logic                      O_TX_READY,
	// status write protection
	input  wire logic                 I_WP_GATE_EN,
	input  wire logic                 I_SR_WR_ACTIVE,
	output logic                      O_WP_BLOCK,
	output logic                      O_SR_COMMIT,
	output logic                      O_SR_ABORT,
	// storage array port
	input  wire logic [AW-1:0]        I_MEM_ADDR,
	input  wire logic [7:0]           I_MEM_WDATA,
	input  wire logic                 I_MEM_WE,
	output logic      [7:0]           O_MEM_RDATA
);

	// ---------------- link domain, SCK ----------------

	logic                      link_rst_n;  // link state clears while deselected
	logic                      sel_pin;     // chip select active
	logic                      run_pin;     // selected and not paused
	logic [`EES_BIT_CNT_W-1:0] rx_cnt;      // rising edges within a byte
	logic [7:0]                rx_shift;    // input shifter
	logic [7:0]                rx_word;     // last whole byte
	logic                      rx_tgl;      // flips once per byte
	logic [`EES_BIT_CNT_W-1:0] tx_cnt;      // falling edges within a byte
	logic [7:0]                tx_shift;    // output shifter
	logic                      tx_live;     // a byte has been loaded this frame
	logic                      tx_req_l1;   // req sync, first stage
	logic                      tx_req_l2;   // req sync, second stage
	logic                      tx_ack;      // flips once per byte taken
	logic                      tx_req;      // flips once per byte offered, core side
	logic [7:0]                tx_hold;     // byte offered to the link, core side

	// deselect is a plain reset of the bit position, so a frame always
	// starts at bit 0 whatever the previous one left behind
	assign sel_pin    = !I_CS_N;
	assign link_rst_n = I_RESET_N && sel_pin;
	// hold only ever changes while SCK is low, so at each edge its level
	// is settled and gates that edge alone
	assign run_pin    = sel_pin && I_HOLD_N;

	// input shifter and bit position on SCK rising
	always_ff @(posedge I_SCK or negedge link_rst_n) begin
		if (!link_rst_n) begin
			rx_cnt   <= '0;
			rx_shift <= `EES_RX_RESET;
		end else if (I_HOLD_N) begin
			// a paused edge touches nothing, the position is kept
			rx_shift <= {rx_shift[6:0], I_SI};
			rx_cnt   <= rx_cnt + `EES_BIT_CNT_W'(1);
		end
	end

	// whole byte capture; kept across frames so the toggle stays paired
	always_ff @(posedge I_SCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			rx_word <= `EES_RX_RESET;
			rx_tgl  <= 1'b0;
		end else if (run_pin && rx_cnt == `EES_BIT_LAST) begin
			rx_word <= {rx_shift[6:0], I_SI};
			rx_tgl  <= !rx_tgl;
		end
	end

	// request from the core synchronised onto the falling edge
	always_ff @(negedge I_SCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tx_req_l1 <= 1'b0;
			tx_req_l2 <= 1'b0;
		end else begin
			tx_req_l1 <= tx_req;
			tx_req_l2 <= tx_req_l1;
		end
	end

	// output shifter on SCK falling
	always_ff @(negedge I_SCK or negedge link_rst_n) begin
		if (!link_rst_n) begin
			tx_cnt   <= '0;
			tx_shift <= `EES_TX_IDLE;
			tx_live  <= 1'b0;
		end else if (I_HOLD_N) begin
			tx_cnt <= tx_cnt + `EES_BIT_CNT_W'(1);
			if (tx_cnt == `EES_BIT_LAST && tx_req_l2 != tx_ack) begin
				// byte boundary with a fresh byte waiting
				tx_shift <= tx_hold;
				tx_live  <= 1'b1;
			end else begin
				tx_shift <= {tx_shift[6:0], 1'b1};
			end
		end
	end

	// acknowledge toggle, survives deselect to stay paired with the request
	always_ff @(negedge I_SCK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tx_ack <= 1'b0;
		end else if (run_pin && tx_cnt == `EES_BIT_LAST && tx_req_l2 != tx_ack) begin
			tx_ack <= !tx_ack;
		end
	end

	// pad drive: data from the shifter, enable only when live and running
	assign O_SO    = tx_shift[7];
	assign O_SO_OE = run_pin && tx_live;

	// ---------------- core domain, I_MCLK ----------------

	logic                  cs_m1;      // chip select sync, first stage
	logic                  cs_m2;      // chip select sync, second stage
	logic                  cs_m3;      // delayed copy for edges
	logic                  hold_m1;    // hold sync, first stage
	logic                  hold_m2;    // hold sync, second stage
	logic                  wp_m1;      // protect pin sync, first stage
	logic                  wp_m2;      // protect pin sync, second stage
	logic                  rxt_m1;     // byte toggle sync, first stage
	logic                  rxt_m2;     // byte toggle sync, second stage
	logic                  rxt_m3;     // delayed copy for change detect
	logic                  ack_m1;     // ack sync, first stage
	logic                  ack_m2;     // ack sync, second stage
	logic                  armed;      // set on the first enabled cycle after reset
	logic                  in_frame;   // frame accepted by the core
	logic                  fall_cs;    // chip select went low
	logic                  rise_cs;    // chip select went high
	logic                  pin_block;  // protect pin is in force
	ees_pkg::ees_sr_state_t sr_state;  // status write progress
	ees_pkg::ees_sr_state_t next_sr_state;

	// two-flop synchronisers for the chip select, hold and protect pins and both crossing toggles
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			cs_m1   <= 1'b1;
			cs_m2   <= 1'b1;
			cs_m3   <= 1'b1;
			hold_m1 <= 1'b1;
			hold_m2 <= 1'b1;
			wp_m1   <= 1'b1;
			wp_m2   <= 1'b1;
			rxt_m1  <= 1'b0;
			rxt_m2  <= 1'b0;
			rxt_m3  <= 1'b0;
			ack_m1  <= 1'b0;
			ack_m2  <= 1'b0;
		end else if (I_CE) begin
			cs_m1   <= I_CS_N;
			cs_m2   <= cs_m1;
			cs_m3   <= cs_m2;
			hold_m1 <= I_HOLD_N;
			hold_m2 <= hold_m1;
			wp_m1   <= I_WP_N;
			wp_m2   <= wp_m1;
			rxt_m1  <= rx_tgl;
			rxt_m2  <= rxt_m1;
			rxt_m3  <= rxt_m2;
			ack_m1  <= tx_ack;
			ack_m2  <= ack_m1;
		end
	end

	assign fall_cs = cs_m3 && !cs_m2;
	assign rise_cs = !cs_m3 && cs_m2;

	// arming: set on the first enabled cycle with synced chip select high, which its reset value gives, so a frame running at reset release is taken
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			armed <= 1'b0;
		end else if (I_CE && cs_m2) begin
			armed <= 1'b1;
		end
	end

	// frame tracking in the core
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			in_frame <= 1'b0;
		end else if (I_CE) begin
			if (fall_cs && armed) begin
				in_frame <= 1'b1;
			end else if (rise_cs) begin
				in_frame <= 1'b0;
			end
		end
	end

	// frame events as registered pulses, selected and paused as registered levels
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_FRAME_START <= 1'b0;
			O_FRAME_END   <= 1'b0;
			O_SELECTED    <= 1'b0;
			O_PAUSED      <= 1'b0;
		end else if (I_CE) begin
			O_FRAME_START <= fall_cs && armed;
			O_FRAME_END   <= rise_cs && in_frame;
			O_SELECTED    <= !cs_m2;
			O_PAUSED      <= !cs_m2 && !hold_m2;
		end
	end

	// received byte hand-off; the link word is steady for a whole byte time
	// and the toggle and chip select share the sync depth, so the last
	// byte is never passed after the frame has been closed
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_RX <= '0;
		end else if (I_CE) begin
			O_RX.valid <= in_frame && (rxt_m2 != rxt_m3);
			if (rxt_m2 != rxt_m3) begin
				O_RX.data <= rx_word;
			end
		end
	end

	// byte offer; a load while not ready is dropped, the held byte stays
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			tx_req  <= 1'b0;
			tx_hold <= `EES_TX_IDLE;
		end else if (I_CE && I_TX_LOAD && O_TX_READY) begin
			tx_req  <= !tx_req;
			tx_hold <= I_TX_BYTE;
		end
	end

	assign O_TX_READY = (tx_req == ack_m2);

	// protect pin matters only with the gate set
	assign pin_block = I_WP_GATE_EN && !wp_m2;

	// status write progress within a frame
	always_comb begin
		next_sr_state = sr_state;
		unique case (sr_state)
			ees_pkg::SR_IDLE: begin
				if (in_frame && I_SR_WR_ACTIVE) begin
					// already low pin refuses at once
					next_sr_state = pin_block ? ees_pkg::SR_KILLED
					                          : ees_pkg::SR_OPEN;
				end
			end
			ees_pkg::SR_OPEN: begin
				if (rise_cs) begin
					next_sr_state = ees_pkg::SR_IDLE;
				end else if (pin_block) begin
					next_sr_state = ees_pkg::SR_KILLED;
				end
			end
			ees_pkg::SR_KILLED: begin
				if (rise_cs) begin
					next_sr_state = ees_pkg::SR_IDLE;
				end
			end
		endcase
	end

	// status write state register
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			sr_state <= ees_pkg::SR_IDLE;
		end else if (I_CE) begin
			sr_state <= next_sr_state;
		end
	end

	// commit starts the self-timed cycle; after it the pin is no longer looked at
	always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			O_SR_COMMIT <= 1'b0;
			O_SR_ABORT  <= 1'b0;
			O_WP_BLOCK  <= 1'b0;
		end else if (I_CE) begin
			O_SR_COMMIT <= rise_cs && sr_state == ees_pkg::SR_OPEN
			               && !pin_block;
			O_SR_ABORT  <= rise_cs && (sr_state == ees_pkg::SR_KILLED
			               || (sr_state == ees_pkg::SR_OPEN && pin_block));
			O_WP_BLOCK  <= pin_block;
		end
	end

	// storage array, reached only through the core side port
	ees_store #(
		.DEPTH (DEPTH),
		.AW    (AW),
		.DW    (8)
	) u_store (
		.i_clk     (I_MCLK),
		.i_reset_n (I_RESET_N),
		.i_ce      (I_CE),
		.i_addr    (I_MEM_ADDR),
		.i_wdata   (I_MEM_WDATA),
		.i_we      (I_MEM_WE),
		.o_rdata   (O_MEM_RDATA)
	);

endmodule

`default_nettype wire

/* File: verilog/ees_store.sv */
`include "ees_defs.svh"
`default_nettype none

// byte storage held in flip-flops, one write port and a registered read
module ees_store #(
	parameter int DEPTH = `EES_DEPTH,
	parameter int AW    = `EES_ADDR_W,
	parameter int DW    = `EES_BYTE_W
) (
	// clock, reset, enable
	input  wire logic          i_clk,
	input  wire logic          i_reset_n,
	input  wire logic          i_ce,
	// access port
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [DW-1:0] i_wdata,
	input  wire logic          i_we,
	output logic      [DW-1:0] o_rdata
);

	logic [DW-1:0] mem [DEPTH]; // the array itself, no reset to keep it cheap

	// write one addressed byte
	always_ff @(posedge i_clk) begin
		if (i_ce && i_we) begin
			mem[i_addr] <= i_wdata;
		end
	end

	// registered read, one cycle after the address
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= '0;
		end else if (i_ce) begin
			o_rdata <= mem[i_addr];
		end
	end

endmodule

`default_nettype wire
